// *** logic/lcd_cfg_params.svh ***
// constants for the display driver command and configuration block
// assumes a byte-wide command stream already deframed from the serial control bus
`ifndef LCD_CFG_PARAMS_SVH
`define LCD_CFG_PARAMS_SVH

`define INV_CMD_VAL 6'h35
`define FILT_CMD_VAL 7'h69
`define BANK_CMD_VAL 6'h02
`define INV_BIT_POS 1
`define WBANK_BIT_POS 1
`define DBANK_BIT_POS 0
`define FILT_BIT_POS 0
`define MUX_DEFAULT 3'h0
`define BIAS_DEFAULT 2'h0
`define PTR_DEFAULT 6'h00
`define FILT_SHIFT 2
`define CMD_MSB 7
`define INV_CMD_LSB 2
`define INV_FIXED_POS 0
`define FILT_CMD_LSB 1
`define BANK_CMD_LSB 2
`define ON_DEFAULT 1'b1
`define OFF_DEFAULT 1'b0
`define BYTE_DEFAULT 8'h00

`endif

// *** logic/lcd_cfg_pkg.sv ***
// types for the display driver configuration block
// assumes lcd_cfg_params.svh holds the numbers
package lcd_cfg_pkg;

typedef enum logic {
    line_inversion,
    frame_inversion
} inversion_scheme_t;

typedef struct packed {
    logic measurement_enable;
    logic compensation_enable;
    logic filter_switch_bit;
    logic pump_enable;
    logic display_enable;
    logic clock_output_enable;
    logic write_bank_select;
    logic display_bank_select;
    inversion_scheme_t inversion_scheme_bit;
    logic [2:0] mux_mode;
    logic [1:0] bias_mode;
    logic [5:0] data_pointer;
} config_t;

endpackage

// *** logic/temp_smoother.sv ***
// temperature sample path: raw pass-through or first-order smoothing
// assumes sample_valid is a one-cycle strobe on mclk
`timescale 1ns/100ps
`include "lcd_cfg_params.svh"

module temp_smoother (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic filter_on,
    input wire logic sample_valid,
    input wire logic [7:0] sample,
    output logic [7:0] temperature_value
);
    logic [7:0] next_temperature_value;
    logic [8:0] diff;

    always_comb begin
        diff = {1'b0, sample} - {1'b0, temperature_value};
        next_temperature_value = temperature_value;
        if (sample_valid) begin
            if (!filter_on) begin
                next_temperature_value = sample;
            end else if (diff[8]) begin
                // moves a quarter of the gap; an integrator, not a true average
                next_temperature_value = temperature_value
                    - 8'((9'(temperature_value - sample) + 9'h3) >> `FILT_SHIFT);
            end else begin
                next_temperature_value = temperature_value + 8'((diff + 9'h3) >> `FILT_SHIFT);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            temperature_value <= `BYTE_DEFAULT;
        end else begin
            temperature_value <= next_temperature_value;
        end
    end
endmodule

// *** logic/lcd_cfg.sv ***
// command decoder and configuration state of the segment display driver
// assumes deframed command bytes with a strobe, and a read strobe for temperature readout
`timescale 1ns/100ps
`include "lcd_cfg_params.svh"

module lcd_cfg (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic read_req,
    input wire logic sample_valid,
    input wire logic [7:0] sample,
    input wire logic frame_clk,
    output logic [7:0] read_data,
    output logic read_valid,
    output lcd_cfg_pkg::config_t cfg,
    output logic drive_polarity,
    output logic outputs_grounded,
    output logic clk_pin_out,
    output logic clk_pin_oe,
    output logic [7:0] temperature_value
);
    // ----------------------------------------
    // frame clock synchroniser
    // ----------------------------------------
    logic frame_s1;
    logic frame_s2;
    logic frame_s3;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            frame_s1 <= `OFF_DEFAULT;
            frame_s2 <= `OFF_DEFAULT;
            frame_s3 <= `OFF_DEFAULT;
        end else begin
            frame_s1 <= frame_clk;
            frame_s2 <= frame_s1;
            frame_s3 <= frame_s2;
        end
    end
    logic frame_edge;
    assign frame_edge = frame_s2 & ~frame_s3;

    // ----------------------------------------
    // temperature path
    // ----------------------------------------
    temp_smoother u_smooth (
        .mclk(mclk),
        .rst_n(rst_n),
        .filter_on(cfg.filter_switch_bit),
        .sample_valid(sample_valid & cfg.measurement_enable),
        .sample(sample),
        .temperature_value(temperature_value)
    );

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic is_inv_cmd;
    logic is_filt_cmd;
    logic is_bank_cmd;
    // the three patterns never overlap, so the tests below need no priority between them
    assign is_inv_cmd = cmd_valid && cmd_byte[`CMD_MSB:`INV_CMD_LSB] == `INV_CMD_VAL
        && !cmd_byte[`INV_FIXED_POS];
    assign is_filt_cmd = cmd_valid && cmd_byte[`CMD_MSB:`FILT_CMD_LSB] == `FILT_CMD_VAL;
    assign is_bank_cmd = cmd_valid && cmd_byte[`CMD_MSB:`BANK_CMD_LSB] == `BANK_CMD_VAL;

    lcd_cfg_pkg::config_t next_cfg;
    always_comb begin
        next_cfg = cfg;
        if (is_inv_cmd) begin
            next_cfg.inversion_scheme_bit =
                lcd_cfg_pkg::inversion_scheme_t'(cmd_byte[`INV_BIT_POS]);
        end
        if (is_filt_cmd) begin
            next_cfg.filter_switch_bit = cmd_byte[`FILT_BIT_POS];
        end
        if (is_bank_cmd) begin
            next_cfg.write_bank_select = cmd_byte[`WBANK_BIT_POS];
            next_cfg.display_bank_select = cmd_byte[`DBANK_BIT_POS];
        end
        // any other byte leaves every field alone
    end

    // reset pin and power-on share rst_n; display memory lives elsewhere
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg.measurement_enable <= `ON_DEFAULT;
            cfg.compensation_enable <= `ON_DEFAULT;
            cfg.filter_switch_bit <= `OFF_DEFAULT;
            cfg.pump_enable <= `OFF_DEFAULT;
            cfg.display_enable <= `OFF_DEFAULT;
            cfg.clock_output_enable <= `OFF_DEFAULT;
            cfg.write_bank_select <= `OFF_DEFAULT;
            cfg.display_bank_select <= `OFF_DEFAULT;
            cfg.inversion_scheme_bit <= lcd_cfg_pkg::line_inversion;
            cfg.mux_mode <= `MUX_DEFAULT;
            cfg.bias_mode <= `BIAS_DEFAULT;
            cfg.data_pointer <= `PTR_DEFAULT;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ----------------------------------------
    // drive polarity and output state
    // ----------------------------------------
    logic next_drive_polarity;
    always_comb begin
        next_drive_polarity = drive_polarity;
        // frame mode flips once per frame so DC cancels over a pair
        if (frame_edge && cfg.inversion_scheme_bit == lcd_cfg_pkg::frame_inversion) begin
            next_drive_polarity = ~drive_polarity;
        end else if (cfg.inversion_scheme_bit == lcd_cfg_pkg::line_inversion) begin
            next_drive_polarity = `OFF_DEFAULT;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive_polarity <= `OFF_DEFAULT;
            outputs_grounded <= `ON_DEFAULT;
        end else begin
            drive_polarity <= next_drive_polarity;
            outputs_grounded <= ~cfg.display_enable;
        end
    end

    // clock pin undriven while output is off
    assign clk_pin_out = 1'b0;
    assign clk_pin_oe = cfg.clock_output_enable;

    // ----------------------------------------
    // temperature readout
    // ----------------------------------------
    logic [7:0] next_read_data;
    logic next_read_valid;
    always_comb begin
        next_read_data = read_data;
        next_read_valid = read_req;
        if (read_req) begin
            next_read_data = temperature_value;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            read_data <= `BYTE_DEFAULT;
            read_valid <= `OFF_DEFAULT;
        end else begin
            read_data <= next_read_data;
            read_valid <= next_read_valid;
        end
    end
endmodule

// *** bench/lcd_cfg_sva.sv ***
// port checker for lcd_cfg
// assumes one mclk domain, sync active-low reset
`timescale 1ns/100ps
module lcd_cfg_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic read_req,
    input wire logic sample_valid,
    input wire logic [7:0] sample,
    input wire logic frame_clk,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire lcd_cfg_pkg::config_t cfg,
    input wire logic drive_polarity,
    input wire logic outputs_grounded,
    input wire logic clk_pin_out,
    input wire logic clk_pin_oe,
    input wire logic [7:0] temperature_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic inv = cmd_valid && cmd_byte[7:2] == 6'h35 && !cmd_byte[0];
    wire logic filt = cmd_valid && cmd_byte[7:1] == 7'h69;
    wire logic bank = cmd_valid && cmd_byte[7:2] == 6'h02;
    wire logic raw = sample_valid && !cfg.filter_switch_bit;
    wire logic frame = cfg.inversion_scheme_bit;
    a_inv_load: assert property (inv |=> cfg.inversion_scheme_bit == $past(cmd_byte[1]))
        else $error("inversion");
    a_filt_load: assert property (filt |=> cfg.filter_switch_bit == $past(cmd_byte[0]))
        else $error("filter");
    a_bank_load: assert property (bank |=> cfg[13:12] == $past(cmd_byte[1:0]))
        else $error("bank");
    a_read_answer: assert property (read_req |=> read_valid && read_data == $past(temperature_value))
        else $error("readout");
    a_raw_sample: assert property (raw |=> temperature_value == $past(sample))
        else $error("raw sample");
    a_reset_state: assert property ($rose(rst_n) |-> cfg == 20'hc0000 && outputs_grounded && !clk_pin_oe)
        else $error("defaults");
    a_stray_cmd: assert property (cmd_valid && !inv && !filt && !bank |=> cfg == $past(cfg))
        else $error("stray command");
    a_frame_flip: assert property ($rose(frame_clk) && frame |-> ##[1:4] ($changed(drive_polarity) || !frame))
        else $error("frame flip");
endmodule
bind lcd_cfg lcd_cfg_sva chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte),
    .read_req(read_req),
    .sample_valid(sample_valid),
    .sample(sample),
    .frame_clk(frame_clk),
    .read_data(read_data),
    .read_valid(read_valid),
    .cfg(cfg),
    .drive_polarity(drive_polarity),
    .outputs_grounded(outputs_grounded),
    .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe),
    .temperature_value(temperature_value)
);

// *** bench/host_model.sv ***
// host stand-in sending command bytes
// assumes free-running mclk; wake wait scaled down
`timescale 1ns/100ps
module host_model #(
    parameter int WAKE = 4,
    parameter int CLEAR_BYTES = 4,
    parameter int SETTLE = 8,
    parameter logic [7:0] INIT_CMD = 8'h00,
    parameter logic [7:0] PUMP_ON = 8'hc2,
    parameter logic [7:0] DISPLAY_ON = 8'h39
) (
    input wire logic mclk,
    output logic cmd_valid = 1'b0,
    output logic [7:0] cmd_byte = 8'h00
);
    task automatic send(input logic [7:0] b);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_byte = b;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_byte = ~b; // stale byte never lingers
    endtask
    // clear bytes, pump and display commands lie outside this block's decode, so they must change nothing
    task automatic start_up();
        repeat (WAKE) @(negedge mclk);
        send(INIT_CMD);
        repeat (CLEAR_BYTES) send(8'h00);
        send(PUMP_ON);
        repeat (SETTLE) @(negedge mclk);
        send(DISPLAY_ON);
    endtask
endmodule

// *** bench/tb_top.sv ***
// random command bench for lcd_cfg
// assumes design, host model and checker compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t bad", $time); end end
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, read_req = 1'b0, sample_valid = 1'b0, frame_clk = 1'b0;
    logic cmd_valid, read_valid, drive_polarity, outputs_grounded, clk_pin_out, clk_pin_oe;
    logic [7:0] sample = 8'h00, cmd_byte, read_data, temperature_value, b, exp_t = 8'h00;
    logic p;
    lcd_cfg_pkg::config_t cfg, exp_c;
    logic [7:0] corner [8] = '{8'hd6, 8'hd7, 8'hd4, 8'hd3, 8'hd2, 8'h0b, 8'h09, 8'h0a};
    int num_errors = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    initial #7 forever #160 frame_clk = ~frame_clk;
    host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
    lcd_cfg dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte),
        .read_req(read_req),
        .sample_valid(sample_valid),
        .sample(sample),
        .frame_clk(frame_clk),
        .read_data(read_data),
        .read_valid(read_valid),
        .cfg(cfg),
        .drive_polarity(drive_polarity),
        .outputs_grounded(outputs_grounded),
        .clk_pin_out(clk_pin_out),
        .clk_pin_oe(clk_pin_oe),
        .temperature_value(temperature_value)
    );
    // bit 17 filter, 13:12 banks, 11 inversion
    function automatic lcd_cfg_pkg::config_t next_exp(lcd_cfg_pkg::config_t e, logic [7:0] c);
        if (c[7:2] == 6'h35 && !c[0]) e[11] = c[1];
        if (c[7:1] == 7'h69) e[17] = c[0];
        if (c[7:2] == 6'h02) e[13:12] = c[1:0];
        return e;
    endfunction
    // raw when the filter is off, else a quarter of the gap, rounded away from the old value
    function automatic logic [7:0] exp_temp(logic [7:0] t, logic [7:0] s, logic f);
        int d = int'(s) - int'(t);
        if (!f) return s;
        if (d < 0) return t - 8'((3 - d) / 4);
        return t + 8'((d + 3) / 4);
    endfunction
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        exp_c = 20'hc0000;
        exp_t = 8'h00;
        `CHK({cfg, outputs_grounded, clk_pin_oe}, {exp_c, 2'b10})
        `CHK({read_valid, read_data, temperature_value, clk_pin_out, drive_polarity}, 19'h0)
        host.start_up();
    endtask
    initial begin
        void'($urandom(32'h9088));
        do_reset();
        for (int i = 0; i < 60; i++) begin
            if (i == 30) do_reset();
            b = (i < 8) ? corner[i] : 8'($urandom);
            host.send(b);
            exp_c = next_exp(exp_c, b);
            `CHK(cfg, exp_c)
            `CHK(read_valid, 1'b0)
            {sample_valid, sample} = {1'b1, 8'($urandom)};
            exp_t = exp_temp(exp_t, sample, exp_c.filter_switch_bit);
            @(negedge mclk);
            {sample_valid, read_req} = 2'b01;
            @(negedge mclk);
            read_req = 1'b0;
            `CHK(read_valid, 1'b1)
            if (!exp_c.filter_switch_bit) `CHK(read_data, sample)
            else `CHK(read_data, exp_t)
            if (exp_c.inversion_scheme_bit == lcd_cfg_pkg::line_inversion) `CHK(drive_polarity, 1'b0)
        end
        // eight mclk periods make one link frame: one frame flips the polarity, the next restores it
        host.send(8'hd6);
        exp_c = next_exp(exp_c, 8'hd6);
        `CHK(cfg, exp_c)
        p = drive_polarity;
        repeat (8) @(negedge mclk);
        `CHK(drive_polarity, ~p)
        repeat (8) @(negedge mclk);
        `CHK(drive_polarity, p)
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        wrap_up();
    end
endmodule
